// >>> logic/spsd_top.sv
`timescale 1ns/1ps
`include "spsd_params.svh"
module spsd_top #(
	parameter int DATA_W = 16,
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// axi4-lite register bus
	input wire spsd_pkg::spsd_addr_t s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire spsd_pkg::spsd_word_t s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire spsd_pkg::spsd_addr_t s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output spsd_pkg::spsd_word_t s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// serializer side
	input wire logic rx_load_i,
	input wire logic [DATA_W-1:0] rx_word_i,
	input wire logic tx_take_i,
	output logic [DATA_W-1:0] tx_word_o,
	output logic tx_word_valid_o,
	input wire logic shifter_idle_i,
	input wire logic mode_fault_i,
	input wire logic select_rise_i,
	input wire logic underrun_i,
	// peripheral dma side
	output logic rx_dma_req_o,
	input wire logic rx_dma_read_i,
	output logic [DATA_W-1:0] rx_dma_data_o,
	output logic tx_dma_req_o,
	input wire logic tx_dma_write_i,
	input wire logic [DATA_W-1:0] tx_dma_data_i,
	// interrupt
	output logic irq_o
);
	import spsd_pkg::*;

	// ==================================================
	// bus slave
	spsd_reg_if rif ();

	spsd_axil_slave u_bus (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.rif(rif.bus)
	);

	// ==================================================
	// declarations
	logic en_r;
	logic hdx_r;
	logic rx_ten_r;
	logic tx_ten_r;
	logic [DATA_W-1:0] rx_hold_r;
	logic rx_full_r;
	logic tx_full_r;
	logic tx_empty_r;
	logic mode_fault_flag_r;
	logic ovr_r;
	logic selr_r;
	logic undr_r;
	logic [`SPSD_EVT_W-1:0] flags;
	logic [`SPSD_EVT_W-1:0] flags_prev_r;
	logic [`SPSD_EVT_W-1:0] isr_r;
	logic [`SPSD_EVT_W-1:0] imr_r;
	spsd_word_t wmask;
	spsd_word_t wbits;
	spsd_word_t status_word;
	logic wr_ctrl;
	logic wr_txh;
	logic wr_rcnt;
	logic wr_rnxt;
	logic wr_tcnt;
	logic wr_tnxt;
	logic wr_xctl;
	logic wr_isr;
	logic wr_imr;
	logic rd_stat;
	logic rd_rxh;
	logic rx_take;
	logic tx_move;
	logic tx_fill;
	logic [DATA_W-1:0] tx_fill_data;
	logic [CNT_W-1:0] rx_cnt;
	logic [CNT_W-1:0] rx_next;
	logic [CNT_W-1:0] tx_cnt;
	logic [CNT_W-1:0] tx_next;
	logic rx_done;
	logic tx_done;
	logic rx_exh;
	logic tx_exh;

	// ==================================================
	// write decode with byte strobes
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_mask
			assign wmask[8*gb +: 8] = {8{rif.wstrb[gb]}};
		end
	endgenerate

	// written bits, masked by the byte strobes
	assign wbits = rif.wdata & wmask;
	assign wr_ctrl = rif.wr_stb && rif.wr_addr == `SPSD_OFF_CTRL;
	assign wr_txh = rif.wr_stb && rif.wr_addr == `SPSD_OFF_TXH;
	assign wr_rcnt = rif.wr_stb && rif.wr_addr == `SPSD_OFF_RCNT;
	assign wr_rnxt = rif.wr_stb && rif.wr_addr == `SPSD_OFF_RNXT;
	assign wr_tcnt = rif.wr_stb && rif.wr_addr == `SPSD_OFF_TCNT;
	assign wr_tnxt = rif.wr_stb && rif.wr_addr == `SPSD_OFF_TNXT;
	assign wr_xctl = rif.wr_stb && rif.wr_addr == `SPSD_OFF_XCTL;
	assign wr_isr = rif.wr_stb && rif.wr_addr == `SPSD_OFF_ISR;
	assign wr_imr = rif.wr_stb && rif.wr_addr == `SPSD_OFF_IMR;
	assign rd_stat = rif.rd_stb && rif.rd_addr == `SPSD_OFF_STAT;
	assign rd_rxh = rif.rd_stb && rif.rd_addr == `SPSD_OFF_RXH;

	// merge of a written value into the old one, byte by byte
	function automatic spsd_word_t merge(input spsd_word_t old_v);
		merge = (old_v & ~wmask) | wbits;
	endfunction

	// ==================================================
	// port control: enable and disable commands, half duplex mode
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			en_r <= 1'b0;
			hdx_r <= 1'b0;
		end else if (wr_ctrl) begin
			hdx_r <= rif.wstrb[0] ? rif.wdata[`SPSD_CTRL_HDX] : hdx_r;
			if (wbits[`SPSD_CTRL_DIS]) begin
				en_r <= 1'b0; // disable wins over enable
			end else if (wbits[`SPSD_CTRL_EN]) begin
				en_r <= 1'b1;
			end
		end
	end

	// dma request enables, set and cleared by command bits
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_ten_r <= 1'b0;
			tx_ten_r <= 1'b0;
		end else if (wr_xctl) begin
			if (wbits[`SPSD_XCTL_RXDIS]) begin
				rx_ten_r <= 1'b0;
			end else if (wbits[`SPSD_XCTL_RXEN]) begin
				rx_ten_r <= 1'b1;
			end
			if (wbits[`SPSD_XCTL_TXDIS]) begin
				tx_ten_r <= 1'b0;
			end else if (wbits[`SPSD_XCTL_TXEN]) begin
				tx_ten_r <= 1'b1;
			end
		end
	end

	// ==================================================
	// receive holding register
	assign rx_take = rd_rxh || rx_dma_read_i;
	assign rx_dma_data_o = rx_hold_r;

	// word captured from the serializer
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_hold_r <= '0;
		end else if (rx_load_i) begin
			rx_hold_r <= rx_word_i;
		end
	end

	// receive full: a load wins over a read in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_full_r <= 1'b0;
		end else if (rx_load_i) begin
			rx_full_r <= 1'b1;
		end else if (rx_take) begin
			rx_full_r <= 1'b0;
		end
	end

	// overrun: a second load before the holding register was read
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ovr_r <= 1'b0;
		end else if (rx_load_i && rx_full_r && !rx_take) begin
			ovr_r <= 1'b1;
		end else if (rd_stat) begin
			ovr_r <= 1'b0;
		end
	end

	// ==================================================
	// transmit holding register, filled by software or dma
	assign tx_fill = wr_txh || tx_dma_write_i;
	assign tx_fill_data = wr_txh ? rif.wdata[DATA_W-1:0] : tx_dma_data_i;
	assign tx_move = tx_take_i && tx_full_r;
	assign tx_word_valid_o = tx_full_r && en_r;

	// held word and its pending flag
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_word_o <= '0;
			tx_full_r <= 1'b0;
		end else if (!en_r) begin
			tx_full_r <= 1'b0;
		end else if (tx_fill) begin
			tx_word_o <= tx_fill_data;
			tx_full_r <= 1'b1;
		end else if (tx_move) begin
			tx_full_r <= 1'b0;
		end
	end

	// transmit empty: zero at reset and while disabled, enable sets it
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_empty_r <= 1'b0;
		end else if (wr_ctrl && wbits[`SPSD_CTRL_DIS]) begin
			tx_empty_r <= 1'b0;
		end else if (wr_ctrl && wbits[`SPSD_CTRL_EN]) begin
			tx_empty_r <= 1'b1;
		end else if (!en_r) begin
			tx_empty_r <= 1'b0;
		end else if (tx_fill) begin
			tx_empty_r <= 1'b0;
		end else if (tx_move) begin
			tx_empty_r <= 1'b1;
		end
	end

	// ==================================================
	// sticky error flags, cleared by a status read; set wins
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mode_fault_flag_r <= 1'b0;
			selr_r <= 1'b0;
			undr_r <= 1'b0;
		end else begin
			if (mode_fault_i) begin
				mode_fault_flag_r <= 1'b1;
			end else if (rd_stat) begin
				mode_fault_flag_r <= 1'b0;
			end
			if (select_rise_i) begin
				selr_r <= 1'b1;
			end else if (rd_stat) begin
				selr_r <= 1'b0;
			end
			if (underrun_i) begin
				undr_r <= 1'b1;
			end else if (rd_stat) begin
				undr_r <= 1'b0;
			end
		end
	end

	// ==================================================
	// dma channels; in half duplex a next-count write goes to both
	spsd_dma_chan #(.CNT_W(CNT_W)) u_rx_dma (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.wr_cnt_i(wr_rcnt),
		.wr_next_i(wr_rnxt || (hdx_r && wr_tnxt)),
		.wdata_i(wr_rcnt ? CNT_W'(merge(32'(rx_cnt)))
			: CNT_W'(merge(32'(hdx_r ? tx_next : rx_next)))),
		.beat_i(rx_dma_read_i),
		.cnt_o(rx_cnt),
		.next_o(rx_next),
		.done_o(rx_done),
		.exhausted_o(rx_exh)
	);

	spsd_dma_chan #(.CNT_W(CNT_W)) u_tx_dma (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.wr_cnt_i(wr_tcnt),
		.wr_next_i(wr_tnxt || (hdx_r && wr_rnxt)),
		.wdata_i(wr_tcnt ? CNT_W'(merge(32'(tx_cnt))) : CNT_W'(merge(32'(tx_next)))),
		.beat_i(tx_dma_write_i),
		.cnt_o(tx_cnt),
		.next_o(tx_next),
		.done_o(tx_done),
		.exhausted_o(tx_exh)
	);

	// requests only while the request enable is set and a word is due; tx also needs the port enabled
	assign rx_dma_req_o = rx_ten_r && rx_full_r && rx_cnt != '0;
	assign tx_dma_req_o = tx_ten_r && tx_empty_r && en_r && tx_cnt != '0;

	// ==================================================
	// status word and interrupt events
	assign flags = {undr_r, tx_empty_r && shifter_idle_i, selr_r, tx_exh, rx_exh,
		tx_done, rx_done, ovr_r, mode_fault_flag_r, tx_empty_r, rx_full_r};
	assign status_word = {15'h0000, en_r, 5'h00, flags};

	// rising flags set sticky bits; write one clears, set wins
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			flags_prev_r <= flags; // no false edge after reset
			isr_r <= `SPSD_RST_EVT;
		end else begin
			flags_prev_r <= flags;
			isr_r <= (isr_r & ~(wr_isr ? wbits[`SPSD_EVT_W-1:0] : `SPSD_RST_EVT))
				| (flags & ~flags_prev_r);
		end
	end

	// interrupt mask and level output
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			imr_r <= `SPSD_RST_EVT;
			irq_o <= 1'b0;
		end else begin
			if (wr_imr) begin
				imr_r <= (imr_r & ~wmask[`SPSD_EVT_W-1:0]) | wbits[`SPSD_EVT_W-1:0];
			end
			irq_o <= |(isr_r & imr_r);
		end
	end

	// ==================================================
	// read mux and address decode
	assign rif.wr_hit = rif.wr_addr[1:0] == 2'b00 && rif.wr_addr <= `SPSD_OFF_IMR;

	always_comb begin
		rif.rdata = `SPSD_RST_WORD;
		rif.rd_hit = 1'b1;
		case (rif.rd_addr)
			`SPSD_OFF_CTRL: rif.rdata = 32'(hdx_r) << `SPSD_CTRL_HDX;
			`SPSD_OFF_STAT: rif.rdata = status_word;
			`SPSD_OFF_RXH: rif.rdata = 32'(rx_hold_r);
			`SPSD_OFF_TXH: rif.rdata = `SPSD_RST_WORD;
			`SPSD_OFF_RCNT: rif.rdata = 32'(rx_cnt);
			`SPSD_OFF_RNXT: rif.rdata = 32'(hdx_r ? tx_next : rx_next);
			`SPSD_OFF_TCNT: rif.rdata = 32'(tx_cnt);
			`SPSD_OFF_TNXT: rif.rdata = 32'(tx_next);
			`SPSD_OFF_XCTL: rif.rdata = `SPSD_RST_WORD;
			`SPSD_OFF_XSTAT: begin
				rif.rdata[`SPSD_XST_RX_REQ_ENABLED] = rx_ten_r;
				rif.rdata[`SPSD_XST_TX_REQ_ENABLED] = tx_ten_r;
			end
			`SPSD_OFF_ISR: rif.rdata = 32'(isr_r);
			`SPSD_OFF_IMR: rif.rdata = 32'(imr_r);
			default: rif.rd_hit = 1'b0;
		endcase
	end
endmodule

// >>> logic/spsd_params.svh
`ifndef SPSD_PARAMS_SVH
`define SPSD_PARAMS_SVH
// ==================================================
// register offsets (byte addresses)
`define SPSD_OFF_CTRL 8'h00
`define SPSD_OFF_STAT 8'h04
`define SPSD_OFF_RXH 8'h08
`define SPSD_OFF_TXH 8'h0C
`define SPSD_OFF_RCNT 8'h10
`define SPSD_OFF_RNXT 8'h14
`define SPSD_OFF_TCNT 8'h18
`define SPSD_OFF_TNXT 8'h1C
`define SPSD_OFF_XCTL 8'h20
`define SPSD_OFF_XSTAT 8'h24
`define SPSD_OFF_ISR 8'h28
`define SPSD_OFF_IMR 8'h2C
// ==================================================
// field positions
`define SPSD_CTRL_EN 0
`define SPSD_CTRL_DIS 1
`define SPSD_CTRL_HDX 2
`define SPSD_XCTL_RXEN 0
`define SPSD_XCTL_RXDIS 1
`define SPSD_XCTL_TXEN 8
`define SPSD_XCTL_TXDIS 9
`define SPSD_XST_RX_REQ_ENABLED 0
`define SPSD_XST_TX_REQ_ENABLED 8
`define SPSD_SR_EN 16
`define SPSD_EVT_W 11
// ==================================================
// reset values
`define SPSD_RST_WORD 32'h0000_0000
`define SPSD_RST_EVT 11'h000
`endif

// >>> logic/spsd_pkg.sv
package spsd_pkg;
	// ==================================================
	// shared types
	typedef logic [31:0] spsd_word_t;
	typedef logic [7:0] spsd_addr_t;
	typedef enum logic [1:0] {
		SPSD_RESP_OKAY = 2'b00,
		SPSD_RESP_SLVERR = 2'b10
	} spsd_resp_t;
endpackage

// >>> logic/spsd_reg_if.sv
`timescale 1ns/1ps
// ==================================================
// register access strobes between bus slave and register file
interface spsd_reg_if;
	import spsd_pkg::*;
	logic wr_stb;
	logic rd_stb;
	spsd_addr_t wr_addr;
	spsd_addr_t rd_addr;
	spsd_word_t wdata;
	logic [3:0] wstrb;
	spsd_word_t rdata;
	logic wr_hit;
	logic rd_hit;
	modport bus (output wr_stb, rd_stb, wr_addr, rd_addr, wdata, wstrb,
		input rdata, wr_hit, rd_hit);
	modport regs (input wr_stb, rd_stb, wr_addr, rd_addr, wdata, wstrb,
		output rdata, wr_hit, rd_hit);
endinterface

// >>> logic/spsd_axil_slave.sv
`timescale 1ns/1ps
`include "spsd_params.svh"
// ==================================================
// axi4-lite slave: one write and one read in flight
module spsd_axil_slave (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// axi4-lite
	input wire spsd_pkg::spsd_addr_t s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire spsd_pkg::spsd_word_t s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire spsd_pkg::spsd_addr_t s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output spsd_pkg::spsd_word_t s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// register side
	spsd_reg_if.bus rif
);
	import spsd_pkg::*;
	logic aw_have_r;
	logic w_have_r;
	logic ar_have_r;

	// ready while the slot is empty and no answer is pending
	assign s_axi_awready_o = !aw_have_r && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_have_r && !s_axi_bvalid_o;
	assign s_axi_arready_o = !ar_have_r && !s_axi_rvalid_o;
	assign rif.wr_stb = aw_have_r && w_have_r && !s_axi_bvalid_o;
	assign rif.rd_stb = ar_have_r && !s_axi_rvalid_o;

	// write address and data, taken in either order
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			rif.wr_addr <= 8'h00;
			rif.wdata <= `SPSD_RST_WORD;
			rif.wstrb <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_r <= 1'b1;
				rif.wr_addr <= s_axi_awaddr_i;
			end else if (rif.wr_stb) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_r <= 1'b1;
				rif.wdata <= s_axi_wdata_i;
				rif.wstrb <= s_axi_wstrb_i;
			end else if (rif.wr_stb) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= SPSD_RESP_OKAY;
		end else if (rif.wr_stb) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= rif.wr_hit ? SPSD_RESP_OKAY : SPSD_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// read address, data capture and response
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ar_have_r <= 1'b0;
			rif.rd_addr <= 8'h00;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= `SPSD_RST_WORD;
			s_axi_rresp_o <= SPSD_RESP_OKAY;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				ar_have_r <= 1'b1;
				rif.rd_addr <= s_axi_araddr_i;
			end else if (rif.rd_stb) begin
				ar_have_r <= 1'b0;
			end
			if (rif.rd_stb) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rif.rdata;
				s_axi_rresp_o <= rif.rd_hit ? SPSD_RESP_OKAY : SPSD_RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end
endmodule

// >>> logic/spsd_dma_chan.sv
`timescale 1ns/1ps
// ==================================================
// one dma direction: current and next count with chaining
module spsd_dma_chan #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// software writes
	input wire logic wr_cnt_i,
	input wire logic wr_next_i,
	input wire logic [CNT_W-1:0] wdata_i,
	// one word moved by the dma
	input wire logic beat_i,
	// state
	output logic [CNT_W-1:0] cnt_o,
	output logic [CNT_W-1:0] next_o,
	output logic done_o,
	output logic exhausted_o
);
	logic last_beat;

	assign last_beat = beat_i && (cnt_o == CNT_W'(1));
	assign exhausted_o = (cnt_o == '0) && (next_o == '0);

	// current count, reloaded from the next count when it runs out
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_o <= '0;
		end else if (wr_cnt_i) begin
			cnt_o <= wdata_i;
		end else if (last_beat) begin
			cnt_o <= next_o;
		end else if (beat_i && cnt_o != '0) begin
			cnt_o <= cnt_o - CNT_W'(1);
		end
	end

	// next count, consumed by the reload
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			next_o <= '0;
		end else if (wr_next_i) begin
			next_o <= wdata_i;
		end else if (last_beat && !wr_cnt_i) begin
			next_o <= '0;
		end
	end

	// end of buffer: set on the last beat of a count; set wins over a next-count write, a count write wins over set
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
		end else if (last_beat && !wr_cnt_i) begin
			done_o <= 1'b1;
		end else if (wr_cnt_i || wr_next_i) begin
			done_o <= 1'b0;
		end
	end
endmodule

// >>> bench/spsd_monitor.sv
`timescale 1ns/1ps
// ==================================================
// bus and datapath checks at the top module's ports
module spsd_monitor #(
	parameter int DATA_W = 16
) (
	// clock and reset
	input logic clock_i,
	input logic rst_i,
	// register bus
	input logic s_axi_awvalid_i,
	input logic s_axi_awready_o,
	input logic s_axi_wvalid_i,
	input logic s_axi_wready_o,
	input logic [1:0] s_axi_bresp_o,
	input logic s_axi_bvalid_o,
	input logic s_axi_bready_i,
	input logic s_axi_arvalid_i,
	input logic s_axi_arready_o,
	input spsd_pkg::spsd_word_t s_axi_rdata_o,
	input logic s_axi_rvalid_o,
	input logic s_axi_rready_i,
	// serializer and dma
	input logic rx_load_i,
	input logic [DATA_W-1:0] rx_word_i,
	input logic tx_take_i,
	input logic [DATA_W-1:0] tx_word_o,
	input logic tx_word_valid_o,
	input logic rx_dma_req_o,
	input logic rx_dma_read_i,
	input logic [DATA_W-1:0] rx_dma_data_o,
	input logic tx_dma_req_o,
	input logic tx_dma_write_i,
	input logic [DATA_W-1:0] tx_dma_data_i,
	// interrupt
	input logic irq_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// one write or one read taken by the slave
	sequence wr_take_s;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence rd_take_s;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	// answers are sampled two edges after the take and stand until accepted
	wr_answer_a: assert property (wr_take_s |-> ##2 s_axi_bvalid_o)
		else $error("no write answer");
	rd_answer_a: assert property (rd_take_s |-> ##2 s_axi_rvalid_o)
		else $error("no read answer");
	b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
		&& $stable(s_axi_bresp_o)) else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable(s_axi_rdata_o)) else $error("read answer dropped");
	// receive holding register load and clear
	rx_land_a: assert property (rx_load_i |=> rx_dma_data_o == $past(rx_word_i))
		else $error("rx word not held");
	rx_clear_a: assert property (rx_dma_read_i && !rx_load_i |=> !rx_dma_req_o)
		else $error("rx full not cleared");
	// transmit holding register
	tx_wait_a: assert property (tx_word_valid_o |-> !tx_dma_req_o)
		else $error("tx request while word waits");
	tx_load_a: assert property (tx_dma_write_i |=> tx_word_valid_o
		&& tx_word_o == $past(tx_dma_data_i)) else $error("tx word not held");
	tx_take_a: assert property (tx_take_i && tx_word_valid_o |=> !tx_word_valid_o)
		else $error("tx word not moved");
	// reset leaves outputs quiet
	reset_quiet_a: assert property (@(posedge clock_i) disable iff (1'b0) rst_i |=>
		!tx_word_valid_o && !irq_o && !s_axi_bvalid_o) else $error("not quiet after reset");
endmodule

bind spsd_top spsd_monitor #(.DATA_W(DATA_W)) i_spsd_monitor (.*);

// >>> bench/spsd_far_model.sv
`timescale 1ns/1ps
// ==================================================
// serializer and peripheral dma stand-in
module spsd_far_model (
	// clock and bench controls
	input logic clock_i,
	input logic dma_on_i,
	input logic take_on_i,
	// serializer side
	output logic rx_load_o,
	output logic [15:0] rx_word_o,
	output logic tx_take_o,
	input logic tx_valid_i,
	output logic idle_o,
	output logic [2:0] evt_o,
	// dma side
	input logic rx_req_i,
	output logic rx_rd_o,
	input logic tx_req_i,
	output logic tx_wr_o,
	output logic [15:0] tx_data_o
);
	// quiet start
	initial {rx_load_o, rx_word_o, tx_take_o, evt_o, rx_rd_o, tx_wr_o, tx_data_o, idle_o} = 40'h00_0000_0001;
	// serializer takes a waiting word unless stalled
	always @(posedge clock_i) begin
		tx_take_o <= tx_valid_i && take_on_i && !tx_take_o;
		idle_o <= !tx_valid_i;
	end
	// dma serves each request with one pulse; data line never rests
	always @(posedge clock_i) begin
		rx_rd_o <= dma_on_i && rx_req_i && !rx_rd_o;
		tx_wr_o <= dma_on_i && tx_req_i && !tx_wr_o;
		tx_data_o <= tx_data_o + 16'h1111;
	end
	// one received word, then the line shows the inverse
	task automatic push_rx(input logic [15:0] w);
		@(posedge clock_i);
		rx_word_o <= w;
		rx_load_o <= 1'b1;
		@(posedge clock_i);
		rx_word_o <= ~w;
		rx_load_o <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask
	// event pulse: 0 mode fault, 1 select rise, 2 underrun
	task automatic pulse(input int k);
		@(posedge clock_i);
		evt_o[k] <= 1'b1;
		@(posedge clock_i);
		evt_o <= 3'h0;
	endtask
endmodule

// >>> bench/spsd_top_tb.sv
`timescale 1ns/1ps
`include "spsd_params.svh"
module spsd_top_tb;
	import spsd_pkg::*;
	// ==================================================
	// stimulus and wires
	logic clk = 1'b0;
	logic rst = 1'b1;
	spsd_addr_t aw_a = 8'h00;
	spsd_addr_t ar_a = 8'h00;
	spsd_word_t w_d = 32'h0000_0000;
	logic aw_v = 1'b0;
	logic w_v = 1'b0;
	logic b_rdy = 1'b0;
	logic ar_v = 1'b0;
	logic r_rdy = 1'b0;
	logic dma_on = 1'b0;
	logic take_on = 1'b0;
	logic [3:0] w_s = 4'hF;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, ld, tk, tv, idl, rq_r, rd_r, rq_t, wr_t;
	logic [1:0] b_rs, r_rs, lr;
	logic [2:0] evt;
	logic [15:0] rx_w, tx_w, tx_d, rx_q;
	spsd_word_t r_d, rv;
	int err_count = 0;
	int compares = 0;
	int bits[3] = '{2, 8, 10};
	spsd_top i_spsd_top (.clock_i(clk), .rst_i(rst), .s_axi_awaddr_i(aw_a),
		.s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
		.s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
		.s_axi_bresp_o(b_rs), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_rdy),
		.s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
		.s_axi_rdata_o(r_d), .s_axi_rresp_o(r_rs), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_rdy),
		.rx_load_i(ld), .rx_word_i(rx_w), .tx_take_i(tk), .tx_word_o(tx_w),
		.tx_word_valid_o(tv), .shifter_idle_i(idl), .mode_fault_i(evt[0]),
		.select_rise_i(evt[1]), .underrun_i(evt[2]), .rx_dma_req_o(rq_r),
		.rx_dma_read_i(rd_r), .rx_dma_data_o(rx_q), .tx_dma_req_o(rq_t),
		.tx_dma_write_i(wr_t), .tx_dma_data_i(tx_d), .irq_o(irq));
	spsd_far_model i_spsd_far_model (.clock_i(clk), .dma_on_i(dma_on), .take_on_i(take_on),
		.rx_load_o(ld), .rx_word_o(rx_w), .tx_take_o(tk), .tx_valid_i(tv), .idle_o(idl),
		.evt_o(evt), .rx_req_i(rq_r), .rx_rd_o(rd_r), .tx_req_i(rq_t), .tx_wr_o(wr_t),
		.tx_data_o(tx_d));
	// 40 MHz clock
	initial forever #12.5 clk = ~clk;
	// ==================================================
	// report and compare
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic tmo();
		err_count++;
		$display("unexpected at %0t: wait ran out", $time);
		tally_and_finish();
	endtask
	task automatic chk_word(input spsd_word_t g, input spsd_word_t e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: word %h not %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: bit %b not %b", $time, g, e);
		end
	endtask
	// ==================================================
	// axi4-lite master
	task automatic wr(input spsd_addr_t a, input spsd_word_t d);
		int n;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (aw_v && aw_rdy) aw_v <= 1'b0;
			if (w_v && w_rdy) w_v <= 1'b0;
			if (b_v) begin
				lr = b_rs;
				b_rdy <= 1'b0;
				break;
			end
		end
		if (n == 50) tmo();
	endtask
	task automatic rd(input spsd_addr_t a);
		int n;
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (ar_v && ar_rdy) ar_v <= 1'b0;
			if (r_v) begin
				rv = r_d;
				lr = r_rs;
				r_rdy <= 1'b0;
				break;
			end
		end
		if (n == 50) tmo();
	endtask
	// one status bit; the read clears sticky flags
	task automatic sbit(input int b, input logic e);
		rd(`SPSD_OFF_STAT);
		chk_bit(rv[b], e);
	endtask
	// status polling until a bit shows, bounded
	task automatic poll(input int b);
		int n;
		for (n = 0; n < 30; n++) begin
			rd(`SPSD_OFF_STAT);
			if (rv[b] === 1'b1) break;
		end
		if (n == 30) tmo();
	endtask
	task automatic wirq(input logic e);
		int n;
		for (n = 0; n < 10; n++) begin
			@(posedge clk);
			if (irq === e) break;
		end
		chk_bit(irq, e);
	endtask
	// ==================================================
	// scenarios
	task automatic t_reset();
		sbit(1, 1'b0);
		sbit(16, 1'b0);
		rd(`SPSD_OFF_XSTAT);
		chk_word(rv, 32'h0000_0000);
		rd(8'h30);
		chk_word({30'h0, lr}, 32'h0000_0002);
		chk_word(rv, 32'h0000_0000);
		$display("end reset");
	endtask
	task automatic t_enable();
		wr(`SPSD_OFF_CTRL, 32'h0000_0001);
		sbit(1, 1'b1);
		chk_bit(rv[16], 1'b1);
		wr(`SPSD_OFF_CTRL, 32'h0000_0003);
		sbit(1, 1'b0);
		chk_bit(rv[16], 1'b0);
		wr(`SPSD_OFF_CTRL, 32'h0000_0001);
		$display("end enable");
	endtask
	task automatic t_rx();
		i_spsd_far_model.push_rx(16'hA5C3);
		sbit(0, 1'b1);
		rd(`SPSD_OFF_RXH);
		chk_word(rv, 32'h0000_A5C3);
		sbit(0, 1'b0);
		i_spsd_far_model.push_rx(16'h0001);
		i_spsd_far_model.push_rx(16'h0002);
		sbit(3, 1'b1);
		chk_bit(rv[0], 1'b1);
		sbit(3, 1'b0);
		rd(`SPSD_OFF_RXH);
		chk_word(rv, 32'h0000_0002);
		$display("end rx");
	endtask
	task automatic t_evt();
		for (int k = 0; k < 3; k++) begin
			i_spsd_far_model.pulse(k);
			sbit(bits[k], 1'b1);
			sbit(bits[k], 1'b0);
		end
		w_s <= 4'h5;
		wr(`SPSD_OFF_RNXT, 32'hFFFF_1234);
		w_s <= 4'hF;
		rd(`SPSD_OFF_RNXT);
		chk_word(rv, 32'h0000_0034);
		$display("end events");
	endtask
	task automatic t_rx_dma();
		wr(`SPSD_OFF_RCNT, 32'h0000_0002);
		wr(`SPSD_OFF_RNXT, 32'h0000_0001);
		wr(`SPSD_OFF_XCTL, 32'h0000_0001);
		rd(`SPSD_OFF_XSTAT);
		chk_word(rv, 32'h0000_0001);
		dma_on <= 1'b1;
		i_spsd_far_model.push_rx(16'h0011);
		i_spsd_far_model.push_rx(16'h0022);
		poll(4);
		rd(`SPSD_OFF_RCNT);
		chk_word(rv, 32'h0000_0001);
		wr(`SPSD_OFF_RNXT, 32'h0000_0000);
		sbit(4, 1'b0);
		i_spsd_far_model.push_rx(16'h0033);
		poll(4);
		sbit(6, 1'b1);
		wr(`SPSD_OFF_RCNT, 32'h0000_0000);
		sbit(4, 1'b0);
		dma_on <= 1'b0;
		wr(`SPSD_OFF_XCTL, 32'h0000_0002);
		rd(`SPSD_OFF_XSTAT);
		chk_word(rv, 32'h0000_0000);
		$display("end rx dma");
	endtask
	task automatic t_tx_dma();
		wr(`SPSD_OFF_TCNT, 32'h0000_0001);
		wr(`SPSD_OFF_TNXT, 32'h0000_0000);
		wr(`SPSD_OFF_XCTL, 32'h0000_0100);
		rd(`SPSD_OFF_XSTAT);
		chk_word(rv, 32'h0000_0100);
		dma_on <= 1'b1;
		poll(5);
		sbit(1, 1'b0);
		take_on <= 1'b1;
		poll(1);
		sbit(9, 1'b1);
		wr(`SPSD_OFF_TNXT, 32'h0000_0003);
		sbit(5, 1'b0);
		dma_on <= 1'b0;
		wr(`SPSD_OFF_XCTL, 32'h0000_0200);
		wr(`SPSD_OFF_CTRL, 32'h0000_0005);
		wr(`SPSD_OFF_TNXT, 32'h0000_0042);
		wr(`SPSD_OFF_CTRL, 32'h0000_0001);
		rd(`SPSD_OFF_RNXT);
		chk_word(rv, 32'h0000_0042);
		$display("end tx dma");
	endtask
	task automatic t_irq();
		wr(`SPSD_OFF_ISR, 32'h0000_07FF);
		wr(`SPSD_OFF_IMR, 32'h0000_0004);
		wirq(1'b0);
		i_spsd_far_model.pulse(0);
		wirq(1'b1);
		wr(`SPSD_OFF_IMR, 32'h0000_0000);
		wirq(1'b0);
		wr(`SPSD_OFF_IMR, 32'h0000_0004);
		wirq(1'b1);
		wr(`SPSD_OFF_ISR, 32'h0000_0004);
		wirq(1'b0);
		$display("end irq");
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_enable();
		t_rx();
		t_evt();
		t_rx_dma();
		t_tx_dma();
		t_irq();
		tally_and_finish();
	end
endmodule
